// >>> shared/filter_pkg.sv
package filter_pkg;

    // ----------------------------------------------------------------
    // datapath widths
    // ----------------------------------------------------------------
    localparam int MOD_W = 4;
    localparam int OUT_W = 24;
    localparam int SINC5_ORDER = 5;
    localparam int SINC5_DECIM = 32;
    localparam int SINC5_LG = 5;
    localparam int S5_W = MOD_W + SINC5_ORDER * SINC5_LG;
    localparam int S1_LG_MAX = 6;
    localparam int S1_W = S5_W + S1_LG_MAX;
    // gain of sinc5 is 2^25; full scale input lands on the output msb
    localparam int NORM_BASE = SINC5_ORDER * SINC5_LG - (OUT_W - MOD_W);
    localparam int S5_PH_W = 5;
    localparam int S1_CNT_W = 6;
    localparam int TICK_W = 7;
    localparam int CONV_CNT_W = 7;
    localparam int SINCE_W = 12;

    // ----------------------------------------------------------------
    // pin codes
    // ----------------------------------------------------------------
    localparam logic [1:0] FILT_LL = 2'h0;
    localparam logic [1:0] FILT_WB_A = 2'h1;
    localparam logic [1:0] FILT_WB_B = 2'h2;
    localparam logic [1:0] FILT_SPARE = 2'h3;
    localparam logic [1:0] RATIO_0 = 2'h0;
    localparam logic [1:0] RATIO_1 = 2'h1;
    localparam logic [1:0] RATIO_2 = 2'h2;
    localparam logic [1:0] RATIO_3 = 2'h3;

    // ----------------------------------------------------------------
    // second stage lengths (log2) and settling
    // ----------------------------------------------------------------
    localparam int LL_LG_0 = 0;
    localparam int LL_LG_1 = 2;
    localparam int LL_LG_2 = 4;
    localparam int LL_LG_3 = 6;
    localparam int WB_LG_0 = 0;
    localparam int WB_LG_1 = 1;
    localparam int WB_LG_2 = 2;
    localparam int WB_LG_3 = 3;
    localparam int LL_SETTLE_CLK_0 = 160;
    localparam int LL_SETTLE_CLK_1 = 288;
    localparam int LL_SETTLE_CLK_2 = 672;
    localparam int LL_SETTLE_CLK_3 = 2208;
    localparam int WB_SETTLE_CONV = 84;

    // ----------------------------------------------------------------
    // wideband fir, symmetric so phase stays linear
    // ----------------------------------------------------------------
    localparam int FIR_TAPS = 5;
    localparam int FIR_LG = 4;
    localparam int FIR_W = OUT_W + 6;
    localparam logic [4:0] FIR_A [FIR_TAPS] =
        '{5'h01, 5'h04, 5'h06, 5'h04, 5'h01};
    localparam logic [4:0] FIR_B [FIR_TAPS] =
        '{5'h02, 5'h03, 5'h06, 5'h03, 5'h02};

    typedef enum {ST_IDLE, ST_SETTLE, ST_RUN} run_state_t;

endpackage : filter_pkg

// >>> core/decim_filter.sv
// Notes on behaviour
// - three paths: low latency sinc, wideband a, wideband b, picked by pins
// - four ratios per path by two pins; word rate is clock over ratio
// - first low latency stage is sinc5 decimating by fixed 32
// - ratio 32 on low latency path bypasses the second sinc stage
// - second stage is moving sum by 4, 16 or 64: ratios 128, 512, 2048
// - response is normalized sinc5 of 32 times normalized sinc1 of N
// - low latency path is linear phase, constant group delay
// - wideband paths are linear phase fir, ratios 32, 64, 128, 256
// - path a transition 0.45-0.55, path b 0.40-0.50 of word rate
// - at 16.384 MHz wideband rates are 512, 256, 128, 64 ksps
// - first settled low latency word after 160, 288, 672, 2208 clocks
// - step settles in 5, 3, 2, 2 words for the four low latency ratios
// - spi mode: ready stays high after start until settled data exist
// - frame sync mode: zero words shifted until first settled data
// - once running every filter result is output, settled or not
// - wideband withholds the first 84 conversions after start
module decim_filter (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // modulator stream, one sample each clock
    input wire logic signed [filter_pkg::MOD_W-1:0] mod_data_i,
    // configuration pins
    input wire logic [1:0] filter_select_pins_i,
    input wire logic [1:0] ratio_select_pins_i,
    input wire logic frame_sync_mode_i,
    // conversion control
    input wire logic start_i,
    input wire logic reset_powerdown_n_i,
    // output words
    output logic signed [filter_pkg::OUT_W-1:0] result_o,
    output logic result_strobe_o,
    output logic conversion_ready_n_o
);
    localparam int NS = filter_pkg::SINC5_ORDER;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    filter_pkg::run_state_t state_reg, state_next;
    logic run_reg, run_next;
    logic [1:0] filt_reg, filt_next, ratio_reg, ratio_next;
    logic signed [filter_pkg::S5_W-1:0] integ_reg [NS], integ_next [NS];
    logic signed [filter_pkg::S5_W-1:0] comb_reg [NS], comb_next [NS];
    logic [filter_pkg::S5_PH_W-1:0] s5_ph_reg, s5_ph_next;
    logic [filter_pkg::S1_CNT_W-1:0] s1_cnt_reg, s1_cnt_next;
    logic signed [filter_pkg::S1_W-1:0] acc_reg, acc_next;
    logic [filter_pkg::TICK_W-1:0] tick_reg, tick_next;
    logic [filter_pkg::CONV_CNT_W-1:0] conv_cnt_reg, conv_cnt_next;
    logic signed [filter_pkg::OUT_W-1:0] tap_reg [filter_pkg::FIR_TAPS-1];
    logic signed [filter_pkg::OUT_W-1:0] tap_next [filter_pkg::FIR_TAPS-1];
    logic signed [filter_pkg::OUT_W-1:0] result_reg, result_next;
    logic strobe_reg, strobe_next, ready_n_reg, ready_n_next;
    logic run_req, restart, s5_tick, conv_tick, is_wb, settled;
    logic [1:0] sel_filt, sel_ratio;
    logic [3:0] lg;
    logic [filter_pkg::S1_CNT_W-1:0] n_m1, load;
    logic [filter_pkg::TICK_W-1:0] ll_ticks;
    logic signed [filter_pkg::S5_W-1:0] stage [NS+1];
    logic signed [filter_pkg::S1_W-1:0] total, shifted;
    logic signed [filter_pkg::OUT_W-1:0] word;
    logic signed [filter_pkg::FIR_W-1:0] fir_sum, fir_out;
    logic [4:0] coef;

    // ----------------------------------------------------------------
    // configuration decode
    // ----------------------------------------------------------------
    always_comb
    begin
        sel_filt = restart ? filter_select_pins_i : filt_reg;
        sel_ratio = restart ? ratio_select_pins_i : ratio_reg;
        // spare code runs the low latency path
        is_wb = (sel_filt == filter_pkg::FILT_WB_A) ||
                (sel_filt == filter_pkg::FILT_WB_B);
        case (sel_ratio)
            filter_pkg::RATIO_0:
            begin
                lg = 4'(is_wb ? filter_pkg::WB_LG_0 : filter_pkg::LL_LG_0);
                ll_ticks = filter_pkg::TICK_W'(filter_pkg::LL_SETTLE_CLK_0 /
                    filter_pkg::SINC5_DECIM);
            end
            filter_pkg::RATIO_1:
            begin
                lg = 4'(is_wb ? filter_pkg::WB_LG_1 : filter_pkg::LL_LG_1);
                ll_ticks = filter_pkg::TICK_W'(filter_pkg::LL_SETTLE_CLK_1 /
                    filter_pkg::SINC5_DECIM);
            end
            filter_pkg::RATIO_2:
            begin
                lg = 4'(is_wb ? filter_pkg::WB_LG_2 : filter_pkg::LL_LG_2);
                ll_ticks = filter_pkg::TICK_W'(filter_pkg::LL_SETTLE_CLK_2 /
                    filter_pkg::SINC5_DECIM);
            end
            default:
            begin
                lg = 4'(is_wb ? filter_pkg::WB_LG_3 : filter_pkg::LL_LG_3);
                ll_ticks = filter_pkg::TICK_W'(filter_pkg::LL_SETTLE_CLK_3 /
                    filter_pkg::SINC5_DECIM);
            end
        endcase
        // lg 0 gives n_m1 0: sinc5 words pass straight through
        n_m1 = filter_pkg::S1_CNT_W'((1 << lg) - 1);
        // phase the second stage so a word lands on the settling clock
        load = is_wb ? n_m1 :
            filter_pkg::S1_CNT_W'((32'(ll_ticks) - 1) % (1 << lg));
    end

    // ----------------------------------------------------------------
    // filter datapath and sequencing
    // ----------------------------------------------------------------
    always_comb
    begin
        run_req = start_i & reset_powerdown_n_i;
        restart = run_req & ~run_reg;
        state_next = state_reg;
        run_next = run_req;
        filt_next = filt_reg;
        ratio_next = ratio_reg;
        integ_next = integ_reg;
        comb_next = comb_reg;
        s5_ph_next = s5_ph_reg;
        s1_cnt_next = s1_cnt_reg;
        acc_next = acc_reg;
        tick_next = tick_reg;
        conv_cnt_next = conv_cnt_reg;
        tap_next = tap_reg;
        result_next = result_reg;
        strobe_next = 1'b0;
        ready_n_next = 1'b1;
        s5_tick = 1'b0;
        conv_tick = 1'b0;
        settled = 1'b0;
        stage[0] = integ_reg[NS-1];
        for (int k = 0; k < NS; k++)
        begin
            stage[k+1] = stage[k] - comb_reg[k];
        end
        total = acc_reg + filter_pkg::S1_W'(stage[NS]);
        shifted = total >>> (filter_pkg::NORM_BASE + int'(lg));
        word = shifted[filter_pkg::OUT_W-1:0];
        fir_sum = '0;
        fir_out = '0;
        coef = '0;
        if (!run_req || restart)
        begin
            // a stopped converter forgets all history, so no stale word
            // from an old ratio can ever reach the output
            state_next = run_req ? filter_pkg::ST_SETTLE : filter_pkg::ST_IDLE;
            filt_next = sel_filt;
            ratio_next = sel_ratio;
            for (int k = 0; k < NS; k++)
            begin
                integ_next[k] = '0;
                comb_next[k] = '0;
            end
            s5_ph_next = '0;
            s1_cnt_next = load;
            acc_next = '0;
            tick_next = '0;
            conv_cnt_next = '0;
            result_next = '0;
            for (int k = 0; k < filter_pkg::FIR_TAPS - 1; k++)
            begin
                tap_next[k] = '0;
            end
        end
        else
        begin
            integ_next[0] = integ_reg[0] + filter_pkg::S5_W'(mod_data_i);
            for (int k = 1; k < NS; k++)
            begin
                integ_next[k] = integ_reg[k] + integ_next[k-1];
            end
            integ_next[NS-1] = integ_reg[NS-1] + integ_next[NS-2];
            stage[0] = integ_next[NS-1];
            for (int k = 0; k < NS; k++)
            begin
                stage[k+1] = stage[k] - comb_reg[k];
            end
            total = acc_reg + filter_pkg::S1_W'(stage[NS]);
            shifted = total >>> (filter_pkg::NORM_BASE + int'(lg));
            word = shifted[filter_pkg::OUT_W-1:0];
            // the fir must see this clock's word, not the one a clock old
            for (int k = 0; k < filter_pkg::FIR_TAPS; k++)
            begin
                coef = (filt_reg == filter_pkg::FILT_WB_B) ?
                    filter_pkg::FIR_B[k] : filter_pkg::FIR_A[k];
                fir_sum = fir_sum + filter_pkg::FIR_W'(
                    (k == 0 ? word : tap_reg[k-1]) *
                    $signed({1'b0, coef}));
            end
            fir_out = fir_sum >>> filter_pkg::FIR_LG;
            s5_ph_next = s5_ph_reg + 1'b1;
            s5_tick = (s5_ph_reg == filter_pkg::S5_PH_W'(
                filter_pkg::SINC5_DECIM - 1));
            if (s5_tick)
            begin
                for (int k = 0; k < NS; k++)
                begin
                    comb_next[k] = stage[k];
                end
                if (tick_reg != '1)
                begin
                    tick_next = tick_reg + 1'b1;
                end
                if (s1_cnt_reg == '0)
                begin
                    conv_tick = 1'b1;
                    acc_next = '0;
                    s1_cnt_next = n_m1;
                end
                else
                begin
                    acc_next = total;
                    s1_cnt_next = s1_cnt_reg - 1'b1;
                end
            end
            if (conv_tick)
            begin
                if (conv_cnt_reg != '1)
                begin
                    conv_cnt_next = conv_cnt_reg + 1'b1;
                end
                if (is_wb)
                begin
                    tap_next[0] = word;
                    for (int k = 1; k < filter_pkg::FIR_TAPS - 1; k++)
                    begin
                        tap_next[k] = tap_reg[k-1];
                    end
                end
                settled = (state_reg == filter_pkg::ST_RUN) ||
                    (is_wb ? (conv_cnt_next > filter_pkg::CONV_CNT_W'(
                        filter_pkg::WB_SETTLE_CONV))
                     : (tick_next >= ll_ticks));
                if (settled)
                begin
                    state_next = filter_pkg::ST_RUN;
                end
                // frame sync words always go out, zero until settled
                strobe_next = settled | frame_sync_mode_i;
                ready_n_next = ~settled;
                result_next = !settled ? '0 :
                    is_wb ? fir_out[filter_pkg::OUT_W-1:0] : word;
            end
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            state_reg <= filter_pkg::ST_IDLE;
            run_reg <= 1'b0;
            filt_reg <= filter_pkg::FILT_LL;
            ratio_reg <= filter_pkg::RATIO_0;
            integ_reg <= '{default: '0};
            comb_reg <= '{default: '0};
            s5_ph_reg <= '0;
            s1_cnt_reg <= '0;
            acc_reg <= '0;
            tick_reg <= '0;
            conv_cnt_reg <= '0;
            tap_reg <= '{default: '0};
            result_reg <= '0;
            strobe_reg <= 1'b0;
            ready_n_reg <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
            run_reg <= run_next;
            filt_reg <= filt_next;
            ratio_reg <= ratio_next;
            integ_reg <= integ_next;
            comb_reg <= comb_next;
            s5_ph_reg <= s5_ph_next;
            s1_cnt_reg <= s1_cnt_next;
            acc_reg <= acc_next;
            tick_reg <= tick_next;
            conv_cnt_reg <= conv_cnt_next;
            tap_reg <= tap_next;
            result_reg <= result_next;
            strobe_reg <= strobe_next;
            ready_n_reg <= ready_n_next;
        end
    end

    assign result_o = result_reg;
    assign result_strobe_o = strobe_reg;
    assign conversion_ready_n_o = ready_n_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [filter_pkg::SINCE_W-1:0] since_reg;
    logic [filter_pkg::SINCE_W-1:0] ll_clk;
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i || restart)
            since_reg <= 12'h001;
        else if (since_reg != '1)
            since_reg <= since_reg + 1'b1;
    end
    always_comb
    begin
        case (ratio_reg)
            filter_pkg::RATIO_0: ll_clk = 12'(filter_pkg::LL_SETTLE_CLK_0);
            filter_pkg::RATIO_1: ll_clk = 12'(filter_pkg::LL_SETTLE_CLK_1);
            filter_pkg::RATIO_2: ll_clk = 12'(filter_pkg::LL_SETTLE_CLK_2);
            default: ll_clk = 12'(filter_pkg::LL_SETTLE_CLK_3);
        endcase
    end

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_restart;
        run_req && !run_reg;
    endsequence
    sequence s_first_word;
        $rose(state_reg == filter_pkg::ST_RUN);
    endsequence

    property p_restart_clears;
        s_restart |=> state_reg == filter_pkg::ST_SETTLE && ready_n_reg;
    endproperty
    a_restart_clears: assert property (p_restart_clears)
        else $error("restart did not clear state");
    property p_ll_settle;
        s_first_word ##0 (!is_wb && !frame_sync_mode_i)
            |-> since_reg == ll_clk + 12'h001 && !conversion_ready_n_o;
    endproperty
    a_ll_settle: assert property (p_ll_settle)
        else $error("low latency first word at wrong clock");
    property p_wb_settle;
        s_first_word ##0 is_wb |-> conv_cnt_reg ==
            filter_pkg::CONV_CNT_W'(filter_pkg::WB_SETTLE_CONV + 1);
    endproperty
    a_wb_settle: assert property (p_wb_settle)
        else $error("wideband first word at wrong conversion");
    property p_ready_pulse;
        !conversion_ready_n_o |=> conversion_ready_n_o;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("ready held low too long");
    property p_spi_gated;
        result_strobe_o && !frame_sync_mode_i |->
            state_reg == filter_pkg::ST_RUN;
    endproperty
    a_spi_gated: assert property (p_spi_gated)
        else $error("word before settling in spi mode");
    property p_frame_zero;
        result_strobe_o && state_reg != filter_pkg::ST_RUN |-> result_o == 0;
    endproperty
    a_frame_zero: assert property (p_frame_zero)
        else $error("unsettled frame word not zero");
    property p_conv_spacing;
        conv_tick |=> (!conv_tick) [*8];
    endproperty
    a_conv_spacing: assert property (p_conv_spacing)
        else $error("conversions too close");
    property p_run_every;
        conv_tick && state_reg == filter_pkg::ST_RUN && run_req
            |=> result_strobe_o;
    endproperty
    a_run_every: assert property (p_run_every)
        else $error("settled conversion not output");
    property p_stopped_quiet;
        !run_req |=> !result_strobe_o && conversion_ready_n_o;
    endproperty
    a_stopped_quiet: assert property (p_stopped_quiet)
        else $error("output while stopped");

endmodule : decim_filter

// >>> verification/mod_source.sv
module mod_source (
    // clock
    input wire logic core_clk_i,
    // control
    input wire logic run_i,
    input wire logic signed [filter_pkg::MOD_W-1:0] level_i,
    // stream
    output logic signed [filter_pkg::MOD_W-1:0] mod_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic signed [filter_pkg::MOD_W-1:0] last_reg = '0;
    always_ff @(posedge core_clk_i)
    begin
        last_reg <= mod_data_o;
    end
    // a stopped modulator churns, so stale data is never mistaken for a hold
    assign mod_data_o = run_i ? level_i : ~last_reg;
endmodule : mod_source

// >>> verification/tb_decim_filter.sv
module tb_decim_filter;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [1:0] filt = 2'h0;
    logic [1:0] ratio = 2'h0;
    logic fsm = 1'b0;
    logic start = 1'b0;
    logic rpd_n = 1'b1;
    logic signed [filter_pkg::MOD_W-1:0] level = 4'sh3;
    logic signed [filter_pkg::MOD_W-1:0] mod_data;
    logic signed [filter_pkg::OUT_W-1:0] result;
    logic strobe;
    logic rdy_n;
    int err_count = 0;
    int tests_run = 0;
    int cycles = 0;
    int n;
    int early;
    int st [4] = '{160, 288, 672, 2208};

    always #2 core_clk_i = ~core_clk_i;

    mod_source mod_source_inst (
        .core_clk_i(core_clk_i),
        .run_i(start),
        .level_i(level),
        .mod_data_o(mod_data)
    );

    decim_filter decim_filter_inst (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .mod_data_i(mod_data),
        .filter_select_pins_i(filt),
        .ratio_select_pins_i(ratio),
        .frame_sync_mode_i(fsm),
        .start_i(start),
        .reset_powerdown_n_i(rpd_n),
        .result_o(result),
        .result_strobe_o(strobe),
        .conversion_ready_n_o(rdy_n)
    );

    task automatic finish_test();
        if (err_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    // the run is about 51k cycles; the ceiling leaves margin
    always @(posedge core_clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 80000)
        begin
            err_count++;
            finish_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // settled dc word: the input level lands on the output msbs
    task automatic check_word(input logic signed [3:0] lv);
        check({8'h00, result}, {8'h00, lv, 20'h00000});
    endtask : check_word

    task automatic wait_word();
        n = 0;
        early = 0;
        forever
        begin
            @(posedge core_clk_i);
            #1;
            n++;
            if (strobe === 1'b1 || n > 30000)
                break;
            if (rdy_n !== 1'b1)
                early++;
        end
    endtask : wait_word

    // pins move only with start low, then start rises
    task automatic start_run(input logic [1:0] f, r, input logic fs);
        @(posedge core_clk_i);
        start <= 1'b0;
        filt <= f;
        ratio <= r;
        fsm <= fs;
        @(posedge core_clk_i);
        start <= 1'b1;
    endtask : start_run

    task automatic t_reset();
        check({31'h0, strobe}, 32'h0);
        check({31'h0, rdy_n}, 32'h1);
        check({8'h00, result}, 32'h0);
    endtask : t_reset

    task automatic t_ll_settle();
        for (int r = 0; r < 4; r++)
        begin
            start_run(r[0] ? filter_pkg::FILT_SPARE : filter_pkg::FILT_LL,
                r[1:0], 1'b0);
            wait_word();
            check(n, st[r] + 1);
            check(early, 0);
            check({31'h0, rdy_n}, 32'h0);
            check_word(level);
            wait_word();
            check(n, 32 << (2 * r));
            check_word(level);
        end
    endtask : t_ll_settle

    task automatic t_frame();
        start_run(filter_pkg::FILT_LL, filter_pkg::RATIO_0, 1'b1);
        for (int k = 1; k <= 5; k++)
        begin
            wait_word();
            check(n, (k == 1) ? 33 : 32);
            if (k < 5)
                check({8'h00, result}, 32'h0);
            else
                check_word(level);
        end
    endtask : t_frame

    task automatic t_wide();
        for (int i = 0; i < 5; i++)
        begin
            start_run((i < 4) ? filter_pkg::FILT_WB_A : filter_pkg::FILT_WB_B,
                (i < 4) ? i[1:0] : 2'h0, 1'b0);
            wait_word();
            check(n, 85 * (32 << (i % 4)) + 1);
            check(early, 0);
            check_word(level);
            wait_word();
            check(n, 32 << (i % 4));
        end
    endtask : t_wide

    task automatic t_step();
        start_run(filter_pkg::FILT_LL, filter_pkg::RATIO_0, 1'b0);
        wait_word();
        @(posedge core_clk_i);
        level <= 4'shE;
        // step lands just after a word, so one extra word covers alignment
        for (int k = 1; k <= 6; k++)
        begin
            wait_word();
            check(n, (k == 1) ? 31 : 32);
            check({31'h0, rdy_n}, 32'h0);
            if (k == 5)
                check_word(4'shE);
        end
        check_word(4'shE);
    endtask : t_step

    task automatic t_restart();
        @(posedge core_clk_i);
        ratio <= filter_pkg::RATIO_1;
        wait_word();
        wait_word();
        check(n, 32);
        @(posedge core_clk_i);
        rpd_n <= 1'b0;
        @(posedge core_clk_i);
        @(posedge core_clk_i);
        #1;
        check({8'h00, result}, 32'h0);
        check({31'h0, rdy_n}, 32'h1);
        @(posedge core_clk_i);
        rpd_n <= 1'b1;
        wait_word();
        check(n, st[1] + 1);
        check_word(4'shE);
    endtask : t_restart

    initial
    begin
        repeat (5) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        #1;
        t_reset();
        t_ll_settle();
        t_frame();
        t_wide();
        t_step();
        t_restart();
        finish_test();
    end
endmodule : tb_decim_filter
